// ### logic/odet_orientation_detector.sv
`include "odet_params.svh"

module odet_orientation_detector (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_sample_valid,
  input wire logic signed [15:0] i_accel_x,
  input wire logic signed [15:0] i_accel_y,
  input wire logic signed [15:0] i_accel_z,
  input wire logic i_standby,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic [3:0] o_output_sample_rate,
  output logic o_low_power,
  output logic o_orient_event
);

  logic [7:0] rate_q;
  logic [7:0] rate_d;
  logic [7:0] setup_q;
  logic [7:0] setup_d;
  logic [7:0] state_q;
  logic [7:0] state_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic pend_q;
  logic pend_d;
  logic [1:0] last_flat_q;
  logic [1:0] last_flat_d;
  logic [2:0] last_face_q;
  logic [2:0] last_face_d;
  logic face_known_q;
  logic face_known_d;
  logic func_rst;
  logic rate_wr;
  logic state_rd;
  logic take;
  logic [2:0] div;
  logic [5:0] dz_k;
  odet_pkg::odet_axis_t filt_q [3];
  odet_pkg::odet_axis_t filt_d [3];
  odet_pkg::odet_axis_t raw [3];
  logic [15:0] mag [3];
  logic x_over_y;
  logic y_over_x;
  logic x_over_z;
  logic y_over_z;
  logic z_over_x;
  logic z_over_y;
  logic flat_valid;
  logic spatial_valid;
  logic [1:0] flat_code;
  logic [2:0] face_code;
  logic ev_flat;
  logic ev_face;
  logic evt;

  assign raw[0] = i_accel_x;
  assign raw[1] = i_accel_y;
  assign raw[2] = i_accel_z;
  assign rate_wr = i_reg_wr && (i_reg_addr == `ODET_ADDR_RATE);
  assign state_rd = i_reg_rd && (i_reg_addr == `ODET_ADDR_STATE);
  assign func_rst = rate_wr || i_standby;
  assign take = i_sample_valid && !func_rst;
  assign div = setup_q[`ODET_DIV_MSB:`ODET_DIV_LSB];

  // Single-pole IIR; 4-bit shift so code 7 cannot wrap to no filter
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_axis
      logic signed [16:0] diff;
      logic signed [16:0] step;
      always_comb
      begin
        diff = 17'(raw[g]) - 17'(filt_q[g]);
        step = diff >>> (4'(div) + 4'h1);
        filt_d[g] = filt_q[g];
        if (func_rst)
          filt_d[g] = 16'sh0000;
        else if (take)
          filt_d[g] = 16'(17'(filt_q[g]) + step);
      end
      always_ff @(posedge i_ref_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          filt_q[g] <= 16'sh0000;
        else
          filt_q[g] <= filt_d[g];
      end
      // Magnitude of the next filtered value; min value gives exact 16'h8000
      assign mag[g] = filt_d[g][15] ? 16'(-17'(filt_d[g])) :
                      filt_d[g];
    end
  endgenerate

  // Scale tan(45 deg + half dead zone) in Q4, zero angle at code 0
  always_comb
  begin
    unique case (setup_q[`ODET_DZ_MSB:`ODET_DZ_LSB])
      3'h0: dz_k = `ODET_DZ_ONE;
      3'h1: dz_k = 6'h12;
      3'h2: dz_k = 6'h14;
      3'h3: dz_k = 6'h16;
      3'h4: dz_k = 6'h18;
      3'h5: dz_k = 6'h1B;
      3'h6: dz_k = 6'h1E;
      3'h7: dz_k = 6'h22;
    endcase
  end

  // Symmetric ratio test keeps the invalid band centred on the bisector
  function automatic logic beats(input logic [15:0] a,
                                 input logic [15:0] b,
                                 input logic [5:0] k);
    logic [21:0] lhs;
    logic [21:0] rhs;
    lhs = {a, 6'h00} >> 2;
    rhs = 22'(b) * 22'(k);
    return lhs > rhs;
  endfunction : beats

  always_comb
  begin
    x_over_y = beats(mag[0], mag[1], dz_k);
    y_over_x = beats(mag[1], mag[0], dz_k);
    x_over_z = beats(mag[0], mag[2], dz_k);
    y_over_z = beats(mag[1], mag[2], dz_k);
    z_over_x = beats(mag[2], mag[0], dz_k);
    z_over_y = beats(mag[2], mag[1], dz_k);
    flat_valid = x_over_y || y_over_x;
    flat_code = 2'(odet_pkg::ODET_FLAT_XPOS);
    if (x_over_y)
      flat_code = filt_d[0][15] ? 2'(odet_pkg::ODET_FLAT_XNEG) :
                  2'(odet_pkg::ODET_FLAT_XPOS);
    else if (y_over_x)
      flat_code = filt_d[1][15] ? 2'(odet_pkg::ODET_FLAT_YNEG) :
                  2'(odet_pkg::ODET_FLAT_YPOS);
    spatial_valid = 1'b1;
    face_code = 3'(odet_pkg::ODET_FACE_FRONT);
    if (x_over_y && x_over_z)
      face_code = filt_d[0][15] ? 3'(odet_pkg::ODET_FACE_BACK) :
                  3'(odet_pkg::ODET_FACE_FRONT);
    else if (y_over_x && y_over_z)
      face_code = filt_d[1][15] ? 3'(odet_pkg::ODET_FACE_RIGHT) :
                  3'(odet_pkg::ODET_FACE_LEFT);
    else if (z_over_x && z_over_y)
      face_code = filt_d[2][15] ? 3'(odet_pkg::ODET_FACE_BOTTOM) :
                  3'(odet_pkg::ODET_FACE_TOP);
    else
      spatial_valid = 1'b0;
    if (!flat_valid)
      flat_code = 2'h0;
    // Default flat is +X, so reset-time +X raises nothing
    ev_flat = flat_valid && (flat_code != last_flat_q);
    ev_face = spatial_valid &&
              (!face_known_q || face_code != last_face_q);
    evt = take && setup_q[`ODET_IRQ_EN_BIT] &&
          (setup_q[`ODET_SPATIAL_BIT] ? ev_face : ev_flat);
  end

  always_comb
  begin
    rate_d = rate_q;
    setup_d = setup_q;
    state_d = state_q;
    last_flat_d = last_flat_q;
    last_face_d = last_face_q;
    face_known_d = face_known_q;
    pend_d = pend_q;
    rdata_d = `ODET_READ_IDLE;
    if (rate_wr)
      rate_d = i_reg_wdata;
    if (i_reg_wr && i_reg_addr == `ODET_ADDR_SETUP)
      setup_d = i_reg_wdata;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        `ODET_ADDR_RATE: rdata_d = rate_q;
        `ODET_ADDR_SETUP: rdata_d = setup_q;
        `ODET_ADDR_STATE: rdata_d = state_q;
        default: rdata_d = `ODET_READ_IDLE;
      endcase
    end
    if (func_rst)
    begin
      state_d = `ODET_STATE_RST;
      last_flat_d = 2'(odet_pkg::ODET_FLAT_XPOS);
      face_known_d = 1'b0;
    end
    else if (take)
    begin
      // One byte write keeps codes and flags coherent
      state_d = 8'h00;
      state_d[`ODET_FLV_BIT] = flat_valid;
      state_d[`ODET_FLC_MSB:`ODET_FLC_LSB] = flat_code;
      state_d[`ODET_SPV_BIT] = spatial_valid;
      state_d[`ODET_SPC_MSB:`ODET_SPC_LSB] =
        spatial_valid ? face_code : 3'h0;
      if (flat_valid)
        last_flat_d = flat_code;
      if (spatial_valid)
      begin
        last_face_d = face_code;
        face_known_d = 1'b1;
      end
    end
    // Status read acknowledges; a same-cycle event still wins
    if (state_rd)
      pend_d = 1'b0;
    if (evt)
      pend_d = 1'b1;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rate_q <= `ODET_RATE_RST;
      setup_q <= `ODET_SETUP_RST;
      state_q <= `ODET_STATE_RST;
      rdata_q <= `ODET_READ_IDLE;
      pend_q <= 1'b0;
      last_flat_q <= 2'h0;
      last_face_q <= 3'h0;
      face_known_q <= 1'b0;
    end
    else
    begin
      rate_q <= rate_d;
      setup_q <= setup_d;
      state_q <= state_d;
      rdata_q <= rdata_d;
      pend_q <= pend_d;
      last_flat_q <= last_flat_d;
      last_face_q <= last_face_d;
      face_known_q <= face_known_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_output_sample_rate = rate_q[`ODET_RATE_MSB:`ODET_RATE_LSB];
  assign o_low_power = rate_q[`ODET_LOWPWR_BIT];
  assign o_orient_event = pend_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_rate_write;
    i_reg_wr && i_reg_addr == `ODET_ADDR_RATE;
  endsequence

  sequence s_state_read;
    i_reg_rd && i_reg_addr == `ODET_ADDR_STATE;
  endsequence

  property p_clear_on_rate;
    s_rate_write |=> state_q == 8'h00 && filt_q[0] == 16'sh0000;
  endproperty
  a_clear_on_rate: assert property (p_clear_on_rate)
    else $error("status not cleared by rate write");
  property p_standby_hold;
    i_standby [*2] |-> state_q == 8'h00 && !face_known_q;
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("status not held clear in standby");
  property p_status_read;
    s_state_read |=> o_reg_rdata == $past(state_q);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read returned wrong byte");
  property p_status_moves;
    !$stable(state_q) |-> $past(i_sample_valid || func_rst);
  endproperty
  a_status_moves: assert property (p_status_moves)
    else $error("status changed without a sample");
  property p_unknown_code_zero;
    !state_q[`ODET_SPV_BIT] |-> state_q[2:0] == 3'h0 &&
      (state_q[`ODET_FLV_BIT] || state_q[5:4] == 2'h0);
  endproperty
  a_unknown_code_zero: assert property (p_unknown_code_zero)
    else $error("code shown while flag clear");
  property p_event_latched;
    evt |=> o_orient_event [*2] or
      (o_orient_event ##1 $past(state_rd));
  endproperty
  a_event_latched: assert property (p_event_latched)
    else $error("event not latched");
  property p_event_needs_enable;
    $rose(o_orient_event) |-> $past(setup_q[`ODET_IRQ_EN_BIT]) &&
      $past(i_sample_valid);
  endproperty
  a_event_needs_enable: assert property (p_event_needs_enable)
    else $error("event raised while disabled");
  property p_pending_holds;
    o_orient_event && !state_rd |=> o_orient_event;
  endproperty
  a_pending_holds: assert property (p_pending_holds)
    else $error("pending event lost before read");
  property p_rate_fields;
    s_rate_write |=> o_output_sample_rate == $past(i_reg_wdata[3:0]) &&
      o_low_power == $past(i_reg_wdata[4]);
  endproperty
  a_rate_fields: assert property (p_rate_fields)
    else $error("rate fields not taken");
  sequence s_default_flat;
    take && flat_valid && flat_code == 2'h0 && !setup_q[`ODET_SPATIAL_BIT];
  endsequence
  property p_flat_default_quiet;
    func_rst ##1 !take ##1 s_default_flat |-> !evt;
  endproperty
  a_flat_default_quiet: assert property (p_flat_default_quiet)
    else $error("event at default flat orientation");
endmodule : odet_orientation_detector

// ### logic/odet_params.svh
`ifndef ODET_PARAMS_SVH
`define ODET_PARAMS_SVH

// Register offsets
`define ODET_ADDR_RATE 8'h2C
`define ODET_ADDR_SETUP 8'h3B
`define ODET_ADDR_STATE 8'h3C

// sample_rate_ctrl fields
`define ODET_RATE_LSB 0
`define ODET_RATE_MSB 3
`define ODET_LOWPWR_BIT 4

// position_setup fields
`define ODET_DIV_LSB 0
`define ODET_DIV_MSB 2
`define ODET_SPATIAL_BIT 3
`define ODET_DZ_LSB 4
`define ODET_DZ_MSB 6
`define ODET_IRQ_EN_BIT 7

// position_state fields
`define ODET_SPC_LSB 0
`define ODET_SPC_MSB 2
`define ODET_SPV_BIT 3
`define ODET_FLC_LSB 4
`define ODET_FLC_MSB 5
`define ODET_FLV_BIT 6

// Reset values
`define ODET_RATE_RST 8'h0A
`define ODET_SETUP_RST 8'h00
`define ODET_STATE_RST 8'h00
`define ODET_READ_IDLE 8'h00

// Dead zone scale is Q4: 16 means no dead zone
`define ODET_DZ_ONE 6'h10

`endif

// ### logic/odet_pkg.sv
package odet_pkg;

  typedef logic signed [15:0] odet_axis_t;

  typedef enum logic [1:0] {
    ODET_FLAT_XPOS,
    ODET_FLAT_XNEG,
    ODET_FLAT_YPOS,
    ODET_FLAT_YNEG
  } odet_flat_t;

  typedef enum logic [2:0] {
    ODET_FACE_FRONT,
    ODET_FACE_BACK,
    ODET_FACE_LEFT,
    ODET_FACE_RIGHT,
    ODET_FACE_TOP,
    ODET_FACE_BOTTOM
  } odet_face_t;

endpackage : odet_pkg

// ### test/odet_host_model.sv
module odet_host_model (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic o_sample_valid,
  output logic signed [15:0] o_accel_x,
  output logic signed [15:0] o_accel_y,
  output logic signed [15:0] o_accel_z,
  output logic o_standby,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    o_sample_valid = 1'b0;
    o_accel_x = 16'h0000;
    o_accel_y = 16'h0000;
    o_accel_z = 16'h0000;
    o_standby = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge i_ref_clk);
    #1;
    o_reg_wr = w;
    o_reg_rd = ~w;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_ref_clk);
    #1;
    q = i_reg_rdata;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    // Idle bus shows garbage, never a stale but plausible value
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : acc

  task automatic smp(input logic signed [15:0] x,
                     input logic signed [15:0] y,
                     input logic signed [15:0] z);
    @(posedge i_ref_clk);
    #1;
    o_sample_valid = 1'b1;
    o_accel_x = x;
    o_accel_y = y;
    o_accel_z = z;
    @(posedge i_ref_clk);
    #1;
    o_sample_valid = 1'b0;
    o_accel_x = ~x;
    o_accel_y = ~y;
    o_accel_z = ~z;
  endtask : smp

  task automatic stby(input logic level);
    @(posedge i_ref_clk);
    #1;
    o_standby = level;
  endtask : stby
endmodule : odet_host_model

// ### test/odet_orientation_detector_bench.sv
module odet_orientation_detector_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk;
  logic rst_b;
  logic sv;
  logic signed [15:0] ax;
  logic signed [15:0] ay;
  logic signed [15:0] az;
  logic sb;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [3:0] rate;
  logic lowp;
  logic ev;
  int failures = 0;
  int compares = 0;

  odet_orientation_detector odet_orientation_detector_inst (
    .i_ref_clk(ref_clk),
    .i_rst_b(rst_b),
    .i_sample_valid(sv),
    .i_accel_x(ax),
    .i_accel_y(ay),
    .i_accel_z(az),
    .i_standby(sb),
    .i_reg_wr(wr),
    .i_reg_rd(rd),
    .i_reg_addr(addr),
    .i_reg_wdata(wdata),
    .o_reg_rdata(rdata),
    .o_output_sample_rate(rate),
    .o_low_power(lowp),
    .o_orient_event(ev)
  );

  odet_host_model odet_host_model_inst (
    .i_ref_clk(ref_clk),
    .i_reg_rdata(rdata),
    .o_sample_valid(sv),
    .o_accel_x(ax),
    .o_accel_y(ay),
    .o_accel_z(az),
    .o_standby(sb),
    .o_reg_wr(wr),
    .o_reg_rd(rd),
    .o_reg_addr(addr),
    .o_reg_wdata(wdata)
  );

  task automatic report_and_stop;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    odet_host_model_inst.acc(1'b1, a, d, q);
  endtask : w

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    odet_host_model_inst.acc(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rdc

  task automatic s(input logic [15:0] x, input logic [15:0] y,
                   input logic [15:0] z);
    odet_host_model_inst.smp(x, y, z);
  endtask : s

  task automatic evc(input logic e);
    chk({7'h00, ev}, {7'h00, e});
  endtask : evc

  task automatic t_regs;
    rdc(8'h2C, 8'h0A);
    chk({3'h0, lowp, rate}, 8'h0A);
    rdc(8'h3B, 8'h00);
    rdc(8'h3C, 8'h00);
    rdc(8'h3D, 8'h00);
    w(8'h3C, 8'hFF);
    rdc(8'h3C, 8'h00);
    w(8'h2C, 8'h1B);
    rdc(8'h2C, 8'h1B);
    chk({3'h0, lowp, rate}, 8'h1B);
    w(8'h3B, 8'h80);
    rdc(8'h3B, 8'h80);
    w(8'h3B, 8'h00);
    w(8'h2C, 8'h0A);
  endtask : t_regs

  task automatic t_codes;
    logic [15:0] v [6][3];
    logic [7:0] e [6];
    v = '{'{16'h0100, 16'h0000, 16'h0000}, '{16'hFF00, 16'h0000, 16'h0000},
          '{16'h0000, 16'h0100, 16'h0000}, '{16'h0000, 16'hFF00, 16'h0000},
          '{16'h0040, 16'h0000, 16'h0100}, '{16'h0040, 16'h0000, 16'hFF00}};
    e = '{8'h48, 8'h59, 8'h6A, 8'h7B, 8'h4C, 8'h4D};
    for (int i = 0; i < 6; i++)
    begin
      w(8'h2C, 8'h0A);
      s(v[i][0], v[i][1], v[i][2]);
      rdc(8'h3C, e[i]);
    end
  endtask : t_codes

  task automatic t_events;
    w(8'h3B, 8'h80);
    w(8'h2C, 8'h0A);
    s(16'h0100, 16'h0000, 16'h0000);
    evc(1'b0);
    s(16'h0000, 16'hFF00, 16'h0000);
    evc(1'b1);
    rdc(8'h3C, 8'h7B);
    evc(1'b0);
    w(8'h2C, 8'h0A);
    w(8'h3B, 8'h88);
    s(16'h0040, 16'h0000, 16'h0100);
    evc(1'b1);
    rdc(8'h3C, 8'h4C);
    evc(1'b0);
    s(16'hFFC0, 16'h0000, 16'h0100);
    evc(1'b0);
    rdc(8'h3C, 8'h5C);
    w(8'h3B, 8'h08);
    w(8'h2C, 8'h0A);
    s(16'h0000, 16'hFF00, 16'h0000);
    evc(1'b0);
  endtask : t_events

  task automatic t_deadzone;
    w(8'h2C, 8'h0A);
    w(8'h3B, 8'h00);
    repeat (12) s(16'h0100, 16'h00C8, 16'h0000);
    rdc(8'h3C, 8'h48);
    w(8'h3B, 8'h70);
    s(16'h0100, 16'h00C8, 16'h0000);
    rdc(8'h3C, 8'h00);
  endtask : t_deadzone

  task automatic t_filter;
    w(8'h2C, 8'h0A);
    w(8'h3B, 8'h00);
    repeat (10) s(16'h0100, 16'h0000, 16'h0000);
    w(8'h3B, 8'h03);
    repeat (2) s(16'h0000, 16'hFF00, 16'h0000);
    rdc(8'h3C, 8'h48);
    w(8'h3B, 8'h00);
    repeat (2) s(16'h0000, 16'hFF00, 16'h0000);
    rdc(8'h3C, 8'h7B);
    w(8'h3B, 8'h07);
    s(16'h0100, 16'h0000, 16'h0000);
    rdc(8'h3C, 8'h7B);
  endtask : t_filter

  task automatic t_standby;
    odet_host_model_inst.stby(1'b1);
    rdc(8'h3C, 8'h00);
    s(16'h0100, 16'h0000, 16'h0000);
    odet_host_model_inst.stby(1'b0);
    rdc(8'h3C, 8'h00);
  endtask : t_standby

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (4000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    t_regs();
    t_codes();
    t_events();
    t_deadzone();
    t_filter();
    t_standby();
    report_and_stop();
  end
endmodule : odet_orientation_detector_bench
